// >>> hdl/sdcd_pkg.sv
// Purpose: constants for the step/direction command decoder
// Assumes: 10 MHz clk_in, straps static after reset release
// Notes:   no software registers; straps and enable polarity are pins
//
// Function
// - straps select pulse+dir high-positive, pulse+dir low-positive, or dual pulse trains.
// - no strap fitted: pulse+dir, direction low positive, high negative.
// - alternative pulse+dir option: direction high positive, low negative.
// - pulse+dir: each step pulse is one increment signed by direction level.
// - dual pulse: step input pulses are clockwise increments, active low.
// - dual pulse: direction input pulses are counter-clockwise increments, active low.
// - drive enabled at enable active level; polarity by input type; open counts enabled.
package sdcd_pkg;

    typedef enum logic [1:0]
    {
        SDCD_MODE_DIR_LOW_POS  = 2'h0,
        SDCD_MODE_DIR_HIGH_POS = 2'h1,
        SDCD_MODE_DUAL_PULSE   = 2'h3
    } sdcd_mode_t;

    localparam int unsigned CLK_HZ          = 10000000;
    localparam int unsigned MIN_PULSE_NS    = 1000;
    localparam int unsigned DIR_SETUP_NS    = 5000;
    localparam int unsigned CLK_PERIOD_NS   = 1000000000 / CLK_HZ;
    // least times round up
    localparam int unsigned MIN_PULSE_CYC   = (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned DIR_SETUP_CYC   = (DIR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0]  SYNC_RESET      = 3'h0;
    localparam logic [1:0]  STEP_IDLE       = 2'h0;

endpackage : sdcd_pkg

// >>> hdl/sdcd_sync.sv
// Purpose: two-flop synchroniser bank for the command pins
// Assumes: inputs asynchronous to clk_in
// Notes:   first stage read only by second stage
module sdcd_sync
(
    // clock and reset
    input  wire logic       clk_in,
    input  wire logic       nrst_in,
    // pins
    input  wire logic [2:0] async_in,
    output logic      [2:0] sync_out
);

    logic [2:0] meta_r;
    logic [2:0] sync_r;

    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            meta_r <= sdcd_pkg::SYNC_RESET;
            sync_r <= sdcd_pkg::SYNC_RESET;
        end
        else
        begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

    assign sync_out = sync_r;

endmodule : sdcd_sync

// >>> hdl/sdcd_decoder.sv
// Purpose: turn step/direction or cw/ccw pulses into signed position increments
// Assumes: 10 MHz clk_in; straps static; pins asynchronous
// Notes:   one increment pulse per active edge, none when cw and ccw edges coincide; enable output from flip-flop
module sdcd_decoder
(
    // clock and reset
    input  wire logic       clk_in,
    input  wire logic       nrst_in,
    // command pins
    input  wire logic       step_pulse_in,
    input  wire logic       direction_in,
    input  wire logic       enable_in,
    // straps
    input  wire logic       strap_pulse_dir_select_in,
    input  wire logic       strap_dual_pulse_select_in,
    input  wire logic       strap_polarity_a_in,
    input  wire logic       strap_polarity_b_in,
    // enable polarity: 1 for sinking inputs, 0 for sourcing/differential
    input  wire logic       enable_active_high_in,
    // position command
    output logic            incr_valid_out,
    output logic            incr_negative_out,
    output logic            drive_enable_out
);

    logic [2:0]         sync_w;
    logic               step_s;
    logic               dir_s;
    logic               en_s;
    logic [1:0]         prev_r;
    logic               fire_r;
    logic               neg_r;
    logic               drv_en_r;
    logic               straps_taken_r;
    sdcd_pkg::sdcd_mode_t mode_r;
    sdcd_pkg::sdcd_mode_t mode_nxt;

    sdcd_sync u_sync
    (
        .clk_in   (clk_in),
        .nrst_in  (nrst_in),
        .async_in ({enable_in, direction_in, step_pulse_in}),
        .sync_out (sync_w)
    );

    assign step_s = sync_w[0];
    assign dir_s  = sync_w[1];
    assign en_s   = sync_w[2];

    // strap decode; dual pulse if dual select set and pulse+dir select clear, else high-positive if polarity a set and b clear, else default
    always_comb
    begin
        if (strap_dual_pulse_select_in && !strap_pulse_dir_select_in)
        begin
            mode_nxt = sdcd_pkg::SDCD_MODE_DUAL_PULSE;
        end
        else if (strap_polarity_a_in && !strap_polarity_b_in)
        begin
            mode_nxt = sdcd_pkg::SDCD_MODE_DIR_HIGH_POS;
        end
        else
        begin
            mode_nxt = sdcd_pkg::SDCD_MODE_DIR_LOW_POS;
        end
    end

    // straps caught once after reset release, as a fitted resistor would be
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            mode_r         <= sdcd_pkg::SDCD_MODE_DIR_LOW_POS;
            straps_taken_r <= 1'b0;
        end
        else if (!straps_taken_r)
        begin
            mode_r         <= mode_nxt;
            straps_taken_r <= 1'b1;
        end
    end

    // open enable pin is expected to float to the active level outside
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            drv_en_r <= 1'b0;
        end
        else
        begin
            drv_en_r <= (en_s == enable_active_high_in);
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            prev_r <= sdcd_pkg::STEP_IDLE;
        end
        else
        begin
            prev_r <= {dir_s, step_s};
        end
    end

    // edge detect on synchronised copies; rising edge in pulse mode, falling in dual
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            fire_r <= 1'b0;
            neg_r  <= 1'b0;
        end
        else
        begin
            fire_r <= 1'b0;
            neg_r  <= 1'b0;
            if (drv_en_r && straps_taken_r)
            begin
                if (mode_r == sdcd_pkg::SDCD_MODE_DUAL_PULSE)
                begin
                    // simultaneous cw and ccw edges cancel
                    if (prev_r[0] && !step_s && !(prev_r[1] && !dir_s))
                    begin
                        fire_r <= 1'b1;
                    end
                    else if (prev_r[1] && !dir_s && !(prev_r[0] && !step_s))
                    begin
                        fire_r <= 1'b1;
                        neg_r  <= 1'b1;
                    end
                end
                else if (!prev_r[0] && step_s)
                begin
                    fire_r <= 1'b1;
                    neg_r  <= (mode_r == sdcd_pkg::SDCD_MODE_DIR_HIGH_POS) ? !dir_s : dir_s;
                end
            end
        end
    end

    assign incr_valid_out    = fire_r;
    assign incr_negative_out = neg_r;
    assign drive_enable_out  = drv_en_r;

    // helper: cycles since step went high
    logic [7:0] hi_cnt_r;
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            hi_cnt_r <= 8'h00;
        end
        else if (!step_s)
        begin
            hi_cnt_r <= 8'h00;
        end
        else if (hi_cnt_r != 8'hff)
        begin
            hi_cnt_r <= hi_cnt_r + 8'h01;
        end
    end

    property p_no_fire_disabled;
        @(posedge clk_in) disable iff (!nrst_in)
        !drv_en_r |=> !fire_r;
    endproperty
    a_no_fire_disabled: assert property (p_no_fire_disabled) else $error("increment while disabled");

    property p_single_fire;
        @(posedge clk_in) disable iff (!nrst_in)
        fire_r |=> !fire_r || (neg_r != $past(neg_r));
    endproperty
    a_single_fire: assert property (p_single_fire) else $error("two increments back to back");

    property p_pd_rise;
        @(posedge clk_in) disable iff (!nrst_in)
        (mode_r != sdcd_pkg::SDCD_MODE_DUAL_PULSE) && drv_en_r && straps_taken_r
            && $rose(step_s) |=> fire_r;
    endproperty
    a_pd_rise: assert property (p_pd_rise) else $error("step edge missed");

    property p_low_pos;
        @(posedge clk_in) disable iff (!nrst_in)
        (mode_r == sdcd_pkg::SDCD_MODE_DIR_LOW_POS) && drv_en_r && straps_taken_r
            && $rose(step_s) |=> (incr_negative_out == $past(dir_s));
    endproperty
    a_low_pos: assert property (p_low_pos) else $error("default sign wrong");

    property p_high_pos;
        @(posedge clk_in) disable iff (!nrst_in)
        (mode_r == sdcd_pkg::SDCD_MODE_DIR_HIGH_POS) && drv_en_r && straps_taken_r
            && $rose(step_s) |=> (incr_negative_out != $past(dir_s));
    endproperty
    a_high_pos: assert property (p_high_pos) else $error("alternative sign wrong");

    property p_cw;
        @(posedge clk_in) disable iff (!nrst_in)
        (mode_r == sdcd_pkg::SDCD_MODE_DUAL_PULSE) && drv_en_r && $fell(step_s)
            && !$fell(dir_s) |=> fire_r && !neg_r;
    endproperty
    a_cw: assert property (p_cw) else $error("cw pulse not counted");

    property p_ccw;
        @(posedge clk_in) disable iff (!nrst_in)
        (mode_r == sdcd_pkg::SDCD_MODE_DUAL_PULSE) && drv_en_r && $fell(dir_s)
            && !$fell(step_s) |=> fire_r && neg_r;
    endproperty
    a_ccw: assert property (p_ccw) else $error("ccw pulse not counted");

    property p_enable;
        @(posedge clk_in) disable iff (!nrst_in)
        ##2 (drv_en_r == ($past(en_s) == $past(enable_active_high_in)));
    endproperty
    a_enable: assert property (p_enable) else $error("enable level wrong");

    property p_mode_static;
        @(posedge clk_in) disable iff (!nrst_in)
        straps_taken_r |=> $stable(mode_r);
    endproperty
    a_mode_static: assert property (p_mode_static) else $error("mode changed");

    c_pd_step:    cover property (@(posedge clk_in) disable iff (!nrst_in)
        fire_r && (mode_r != sdcd_pkg::SDCD_MODE_DUAL_PULSE));
    c_ccw_step:   cover property (@(posedge clk_in) disable iff (!nrst_in)
        fire_r && neg_r && (mode_r == sdcd_pkg::SDCD_MODE_DUAL_PULSE));
    c_long_pulse: cover property (@(posedge clk_in) disable iff (!nrst_in)
        hi_cnt_r == 8'(sdcd_pkg::MIN_PULSE_CYC));
    c_disabled:   cover property (@(posedge clk_in) disable iff (!nrst_in)
        !drv_en_r && $rose(step_s));

endmodule : sdcd_decoder

// >>> dv/sdcd_ctrl_model.sv
// Purpose: motion controller model driving the step and direction pins
// Assumes: 10 MHz clk_in; pins change 5 ns after a rising edge
// Notes:   pulse widths kept above the minimum so the decoder never sees a runt
module sdcd_ctrl_model
(
    // clock
    input  wire logic clk_in,
    // command pins
    output logic      step_out,
    output logic      dir_out
);
    timeunit 1ns;
    timeprecision 1ns;

    initial
    begin
        step_out = 1'b0;
        dir_out  = 1'b0;
    end

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_in);
        #5;
    endtask : wait_cyc

    // dual mode idles high, pulse mode low
    task automatic idle(input logic lvl);
        wait_cyc(1);
        step_out = lvl;
        dir_out  = lvl;
    endtask : idle

    task automatic dir_step(input logic dir_lvl);
        wait_cyc(1);
        dir_out = dir_lvl;
        wait_cyc(50);
        step_out = 1'b1;
        wait_cyc(12);
        step_out = 1'b0;
        wait_cyc(12);
    endtask : dir_step

    task automatic low_pulse(input logic on_dir);
        wait_cyc(1);
        if (on_dir)
            dir_out = 1'b0;
        else
            step_out = 1'b0;
        wait_cyc(12);
        dir_out  = 1'b1;
        step_out = 1'b1;
        wait_cyc(12);
    endtask : low_pulse

endmodule : sdcd_ctrl_model

// >>> dv/step_dir_command_decoder_bench.sv
// Purpose: self-checking bench for the step/direction command decoder
// Assumes: straps latched after reset, so each mode gets its own reset
// Notes:   increments counted by sign; totals compared per scenario
`define CHK(what, exp, got) \
    begin \
        checked++; \
        if ((got) !== (exp)) \
        begin \
            fails++; \
            $display("[ERR] %s expected %0h seen %0h", what, exp, got); \
        end \
    end

module step_dir_command_decoder_bench;
    timeunit 1ns;
    timeprecision 1ns;

    logic       clk_in = 1'b0;
    logic       nrst_in = 1'b0;
    logic       enable_in = 1'b1;
    logic [3:0] straps = 4'h0;
    logic       enable_active_high_in = 1'b1;
    logic       step_pin;
    logic       dir_pin;
    logic       incr_valid_out;
    logic       incr_negative_out;
    logic       drive_enable_out;
    int         pos_cnt = 0;
    int         neg_cnt = 0;
    int         fails = 0;
    int         checked = 0;

    initial
    begin
        forever #50 clk_in = ~clk_in;
    end

    sdcd_ctrl_model u_ctrl (.clk_in(clk_in), .step_out(step_pin), .dir_out(dir_pin));

    sdcd_decoder u_dut
    (
        .clk_in                     (clk_in),
        .nrst_in                    (nrst_in),
        .step_pulse_in              (step_pin),
        .direction_in               (dir_pin),
        .enable_in                  (enable_in),
        .strap_pulse_dir_select_in  (straps[3]),
        .strap_dual_pulse_select_in (straps[2]),
        .strap_polarity_a_in        (straps[1]),
        .strap_polarity_b_in        (straps[0]),
        .enable_active_high_in      (enable_active_high_in),
        .incr_valid_out             (incr_valid_out),
        .incr_negative_out          (incr_negative_out),
        .drive_enable_out           (drive_enable_out)
    );

    always @(posedge clk_in)
    begin
        if (incr_valid_out === 1'b1)
        begin
            if (incr_negative_out === 1'b1)
                neg_cnt++;
            else
                pos_cnt++;
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #5;
    endtask : tick

    task automatic do_reset(input logic [3:0] s);
        tick(1);
        straps  = s;
        nrst_in = 1'b0;
        tick(12);
        nrst_in = 1'b1;
        tick(6);
        pos_cnt = 0;
        neg_cnt = 0;
    endtask : do_reset

    task automatic expect_incr(input string what, input int p, input int n);
        tick(10);
        `CHK({what, " pos"}, p, pos_cnt)
        `CHK({what, " neg"}, n, neg_cnt)
        pos_cnt = 0;
        neg_cnt = 0;
    endtask : expect_incr

    task automatic t_default;
        do_reset(4'h0);
        `CHK("enable", 1'b1, drive_enable_out)
        u_ctrl.dir_step(1'b0);
        u_ctrl.dir_step(1'b1);
        u_ctrl.dir_step(1'b1);
        expect_incr("default", 1, 2);
        $display("t_default done");
    endtask : t_default

    task automatic t_high_pos;
        do_reset(4'h2);
        u_ctrl.dir_step(1'b1);
        u_ctrl.dir_step(1'b1);
        u_ctrl.dir_step(1'b0);
        expect_incr("high_pos", 2, 1);
        $display("t_high_pos done");
    endtask : t_high_pos

    task automatic t_enable;
        do_reset(4'h0);
        enable_in = 1'b0;
        tick(5);
        `CHK("disabled", 1'b0, drive_enable_out)
        u_ctrl.dir_step(1'b0);
        expect_incr("gated", 0, 0);
        enable_active_high_in = 1'b0;
        tick(5);
        `CHK("low enable", 1'b1, drive_enable_out)
        u_ctrl.dir_step(1'b1);
        expect_incr("low enabled", 0, 1);
        enable_in = 1'b1;
        tick(5);
        `CHK("low disabled", 1'b0, drive_enable_out)
        $display("t_enable done");
    endtask : t_enable

    task automatic t_dual;
        enable_active_high_in = 1'b1;
        u_ctrl.idle(1'b1);
        do_reset(4'h4);
        u_ctrl.low_pulse(1'b0);
        u_ctrl.low_pulse(1'b0);
        u_ctrl.low_pulse(1'b1);
        expect_incr("dual", 2, 1);
        u_ctrl.idle(1'b0);
        tick(12);
        u_ctrl.idle(1'b1);
        expect_incr("dual cancel", 0, 0);
        $display("t_dual done");
    endtask : t_dual

    // straps with the select bit set, together with both polarity bits, the dual bit, or the first polarity bit
    task automatic t_straps;
        u_ctrl.idle(1'b0);
        do_reset(4'hb);
        u_ctrl.dir_step(1'b1);
        expect_incr("both polarity", 0, 1);
        do_reset(4'hc);
        u_ctrl.dir_step(1'b0);
        expect_incr("pd over dual", 1, 0);
        do_reset(4'ha);
        u_ctrl.dir_step(1'b1);
        expect_incr("pd high_pos", 1, 0);
        $display("t_straps done");
    endtask : t_straps

    task automatic conclude;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : conclude

    // hang guard
    initial
    begin
        repeat (50000) @(posedge clk_in);
        fails++;
        conclude();
    end

    initial
    begin
        t_default();
        t_high_pos();
        t_enable();
        t_dual();
        t_straps();
        conclude();
    end

endmodule : step_dir_command_decoder_bench
